// ---- hdl/tdf_diag_flags.sv ----
// diagnostic status, soft control and alarm/warning flag bank on ahb-lite
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tdf_diag_flags
    import tdf_pkg::*;
#(
    parameter int RESPONSE_LIMIT = RESPONSE_CYCLES
) (
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // module pins and monitor values
    input  wire tdf_pins_t   pins,
    input  wire tdf_meas_t   meas,
    input  wire tdf_thr_t    thr,
    input  wire logic        measUpdate,
    // transmitter control
    output logic             txDisableOut
);

    tdf_state_t s_q;
    tdf_state_t s_d;
    logic       addrTake;
    logic       wrTake;
    logic [7:0] stsByte;
    logic [3:0] tempEv;
    logic [3:0] vccEv;
    logic [3:0] biasEv;
    logic [3:0] txEv;
    logic [3:0] rxEv;

    // returns {hiAlarm, loAlarm, hiWarn, loWarn} crossings
    function automatic logic [3:0] evalLimits(
        input logic [15:0] v,
        input tdf_limit_t  l,
        input logic        isSigned
    );
        logic [16:0] ve;
        logic [16:0] ha;
        logic [16:0] la;
        logic [16:0] hw;
        logic [16:0] lw;
        // sign or zero extend so one signed compare serves both codings
        ve = {isSigned & v[15], v};
        ha = {isSigned & l.hiAlarm[15], l.hiAlarm};
        la = {isSigned & l.loAlarm[15], l.loAlarm};
        hw = {isSigned & l.hiWarn[15], l.hiWarn};
        lw = {isSigned & l.loWarn[15], l.loWarn};
        evalLimits = {$signed(ve) > $signed(ha), $signed(ve) < $signed(la),
                      $signed(ve) > $signed(hw), $signed(ve) < $signed(lw)};
    endfunction : evalLimits

    // register read mux; unmapped indices read zero
    function automatic logic [31:0] readReg(
        input logic [7:0] idx,
        input tdf_state_t st,
        input logic [7:0] sts
    );
        readReg = RST_RDATA;
        unique case (idx)
            IDX_STATUS:   readReg[7:0] = sts;
            IDX_ALARM_UP: readReg[7:0] = st.alarmUp;
            IDX_ALARM_LO: readReg[7:0] = {st.alarmLo, 6'h00};
            IDX_WARN_UP:  readReg[7:0] = st.warnUp;
            IDX_WARN_LO:  readReg[7:0] = {st.warnLo, 6'h00};
            default:      readReg = RST_RDATA;
        endcase
    endfunction : readReg

    // zero wait state; a low enable stalls the bus rather than drop a beat
    assign hreadyout    = ce;
    assign hresp        = 1'b0;
    assign hrdata       = s_q.rdata;
    assign txDisableOut = s_q.txOff;

    assign addrTake = ce & hsel & hready & (htrans == HTRANS_NONSEQ);
    assign wrTake   = ce & s_q.wrPend;

    assign stsByte = {s_q.stsTxPin, s_q.softTx, 3'h0,
                      s_q.stsFault, s_q.stsLos, s_q.notReady};

    assign tempEv = evalLimits(meas.temp,  thr.temp,  1'b1);
    assign vccEv  = evalLimits(meas.vcc,   thr.vcc,   1'b0);
    assign biasEv = evalLimits(meas.bias,  thr.bias,  1'b0);
    assign txEv   = evalLimits(meas.txPwr, thr.txPwr, 1'b0);
    assign rxEv   = evalLimits(meas.rxPwr, thr.rxPwr, 1'b0);

    always_comb begin
        s_d = s_q;
        if (ce) begin
            // data phase of a write: only the soft inhibit is writable
            if (wrTake) begin
                s_d.wrPend = 1'b0;
                if (s_q.wrIdx == IDX_STATUS) begin
                    s_d.softTx = hwdata[STS_SOFTTX_BIT];
                end
            end
            if (addrTake) begin
                s_d.wrPend = hwrite;
                s_d.wrIdx  = haddr[9:2];
                s_d.rdata  = hwrite ? RST_RDATA
                                    : readReg(haddr[9:2], s_q, stsByte);
            end
            // pins are mirrored every enabled cycle, far inside the response time
            s_d.stsTxPin = pins.txDisablePin;
            s_d.stsFault = pins.laserFault;
            s_d.stsLos   = pins.receiveSignalLossOutput;
            s_d.txOff    = pins.txDisablePin | s_d.softTx;
            if (measUpdate) begin
                s_d.notReady = 1'b0;
                // flags follow the latest sample, so they clear on return
                s_d.alarmUp = {tempEv[3:2], vccEv[3:2],
                               biasEv[3:2], txEv[3:2]};
                s_d.alarmLo = rxEv[3:2];
                s_d.warnUp  = {tempEv[1:0], vccEv[1:0],
                               biasEv[1:0], txEv[1:0]};
                s_d.warnLo  = rxEv[1:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '{wrPend: 1'b0, wrIdx: 8'h00, rdata: RST_RDATA,
                     softTx: RST_SOFTTX, txOff: 1'b0, stsTxPin: 1'b0,
                     stsFault: 1'b0, stsLos: 1'b0, notReady: RST_NRDY,
                     alarmUp: RST_FLAGS, alarmLo: RST_FLAGS2,
                     warnUp: RST_FLAGS, warnLo: RST_FLAGS2};
        end else begin
            s_q <= s_d;
        end
    end

    // helper: cycles the transmitter control disagrees with its causes
    logic [31:0] lagCnt_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lagCnt_q <= 32'h0000_0000;
        end else if (s_q.txOff != (pins.txDisablePin | s_q.softTx)) begin
            lagCnt_q <= lagCnt_q + 32'h0000_0001;
        end else begin
            lagCnt_q <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_pin_mirror_tx: assert property (ce |=>
        s_q.stsTxPin == $past(pins.txDisablePin))
        else $error("tx inhibit mirror wrong");

    a_soft_write_bit: assert property (
        wrTake && s_q.wrIdx == IDX_STATUS |=>
        s_q.softTx == $past(hwdata[STS_SOFTTX_BIT]))
        else $error("soft inhibit not written");

    a_soft_hold: assert property (
        !(wrTake && s_q.wrIdx == IDX_STATUS) |=> $stable(s_q.softTx))
        else $error("soft inhibit moved without write");

    a_tx_off_or: assert property (ce |=>
        txDisableOut == ($past(pins.txDisablePin) | s_q.softTx))
        else $error("transmitter disable not or of sources");

    a_fault_mirror: assert property (ce |=>
        s_q.stsFault == $past(pins.laserFault))
        else $error("fault mirror wrong");

    a_los_mirror: assert property (ce |=>
        s_q.stsLos == $past(pins.receiveSignalLossOutput))
        else $error("loss mirror wrong");

    a_ready_after_update: assert property (
        s_q.notReady && !(ce && measUpdate) |=> s_q.notReady)
        else $error("ready without measurement");

    a_ready_clears: assert property (
        ce && measUpdate |=> !s_q.notReady)
        else $error("not ready after measurement");

    a_ready_stays: assert property (
        !s_q.notReady |=> !s_q.notReady)
        else $error("not ready set again without reset");

    a_response_bound: assert property (
        lagCnt_q < RESPONSE_LIMIT)
        else $error("control response too slow");

    a_temp_hi_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_TEMP_HI] ==
        ($signed($past(meas.temp)) > $signed($past(thr.temp.hiAlarm))))
        else $error("temperature high alarm wrong");

    a_vcc_lo_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_VCC_HI-1] ==
        ($past(meas.vcc) < $past(thr.vcc.loAlarm)))
        else $error("supply low alarm wrong");

    a_bias_hi_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_BIAS_HI] ==
        ($past(meas.bias) > $past(thr.bias.hiAlarm)))
        else $error("bias high alarm wrong");

    a_txpwr_lo_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_TXPWR_HI-1] ==
        ($past(meas.txPwr) < $past(thr.txPwr.loAlarm)))
        else $error("tx power low alarm wrong");

    a_temp_lo_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_TEMP_HI-1] ==
        ($signed($past(meas.temp)) < $signed($past(thr.temp.loAlarm))))
        else $error("temperature low alarm wrong");

    a_vcc_hi_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_VCC_HI] ==
        ($past(meas.vcc) > $past(thr.vcc.hiAlarm)))
        else $error("supply high alarm wrong");

    a_bias_lo_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_BIAS_HI-1] ==
        ($past(meas.bias) < $past(thr.bias.loAlarm)))
        else $error("bias low alarm wrong");

    a_txpwr_hi_alarm: assert property (ce && measUpdate |=>
        s_q.alarmUp[FLG_TXPWR_HI] ==
        ($past(meas.txPwr) > $past(thr.txPwr.hiAlarm)))
        else $error("tx power high alarm wrong");

    a_rx_alarm_pair: assert property (ce && measUpdate |=>
        s_q.alarmLo == {$past(meas.rxPwr) > $past(thr.rxPwr.hiAlarm),
                        $past(meas.rxPwr) < $past(thr.rxPwr.loAlarm)})
        else $error("rx power alarms wrong");

    a_rx_reserved_zero: assert property (
        s_q.rdata[5:0] == 6'h00 || !$past(addrTake)
        || $past(haddr[9:2]) == IDX_STATUS
        || $past(haddr[9:2]) == IDX_ALARM_UP
        || $past(haddr[9:2]) == IDX_WARN_UP)
        else $error("reserved flag bits not zero");

    a_temp_lo_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_TEMP_HI-1] ==
        ($signed($past(meas.temp)) < $signed($past(thr.temp.loWarn))))
        else $error("temperature low warning wrong");

    a_vcc_hi_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_VCC_HI] ==
        ($past(meas.vcc) > $past(thr.vcc.hiWarn)))
        else $error("supply high warning wrong");

    a_bias_lo_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_BIAS_HI-1] ==
        ($past(meas.bias) < $past(thr.bias.loWarn)))
        else $error("bias low warning wrong");

    a_txpwr_hi_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_TXPWR_HI] ==
        ($past(meas.txPwr) > $past(thr.txPwr.hiWarn)))
        else $error("tx power high warning wrong");

    a_rx_warn_pair: assert property (ce && measUpdate |=>
        s_q.warnLo == {$past(meas.rxPwr) > $past(thr.rxPwr.hiWarn),
                       $past(meas.rxPwr) < $past(thr.rxPwr.loWarn)})
        else $error("rx power warnings wrong");

    a_temp_hi_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_TEMP_HI] ==
        ($signed($past(meas.temp)) > $signed($past(thr.temp.hiWarn))))
        else $error("temperature high warning wrong");

    a_vcc_lo_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_VCC_HI-1] ==
        ($past(meas.vcc) < $past(thr.vcc.loWarn)))
        else $error("supply low warning wrong");

    a_bias_hi_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_BIAS_HI] ==
        ($past(meas.bias) > $past(thr.bias.hiWarn)))
        else $error("bias high warning wrong");

    a_txpwr_lo_warn: assert property (ce && measUpdate |=>
        s_q.warnUp[FLG_TXPWR_HI-1] ==
        ($past(meas.txPwr) < $past(thr.txPwr.loWarn)))
        else $error("tx power low warning wrong");

    a_flags_hold: assert property (!(ce && measUpdate) |=>
        $stable(s_q.alarmUp) && $stable(s_q.warnUp)
        && $stable(s_q.alarmLo) && $stable(s_q.warnLo))
        else $error("flags moved without update");

    a_status_unused: assert property (
        $past(addrTake) && !$past(hwrite)
        && $past(haddr[9:2]) == IDX_STATUS |->
        // read data holds the mirror as it stood at the address phase
        s_q.rdata[5:3] == 3'h0 && s_q.rdata[7] == $past(s_q.stsTxPin))
        else $error("status layout wrong");

    c_soft_write: cover property (wrTake && s_q.wrIdx == IDX_STATUS
        && hwdata[STS_SOFTTX_BIT]);
    c_status_read: cover property (addrTake && !hwrite
        && haddr[9:2] == IDX_STATUS);
    c_alarm_set_clear: cover property (s_q.alarmUp != RST_FLAGS
        ##[1:50] s_q.alarmUp == RST_FLAGS);
    c_ready: cover property ($fell(s_q.notReady));
    c_tx_by_pin: cover property (pins.txDisablePin && !s_q.softTx
        ##1 txDisableOut);

endmodule : tdf_diag_flags

`default_nettype wire

// ---- shared/tdf_pkg.sv ----
// shared constants and types for the transceiver diagnostic flag bank
package tdf_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS    = 8'h6e;
    localparam logic [7:0] IDX_ALARM_UP  = 8'h70;
    localparam logic [7:0] IDX_ALARM_LO  = 8'h71;
    localparam logic [7:0] IDX_WARN_UP   = 8'h74;
    localparam logic [7:0] IDX_WARN_LO   = 8'h75;

    // status/control byte fields
    localparam int STS_TXPIN_BIT  = 7;
    localparam int STS_SOFTTX_BIT = 6;
    localparam int STS_FAULT_BIT  = 2;
    localparam int STS_LOS_BIT    = 1;
    localparam int STS_NRDY_BIT   = 0;

    // flag byte field positions (quantity high bit; low bit is one below)
    localparam int FLG_TEMP_HI  = 7;
    localparam int FLG_VCC_HI   = 5;
    localparam int FLG_BIAS_HI  = 3;
    localparam int FLG_TXPWR_HI = 1;
    localparam int FLG_RXPWR_HI = 7;

    // reset values
    localparam logic [7:0]  RST_FLAGS  = 8'h00;
    localparam logic [1:0]  RST_FLAGS2 = 2'h0;
    localparam logic        RST_SOFTTX = 1'b0;
    localparam logic        RST_NRDY   = 1'b1;
    localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

    // response time of soft controls and pin mirrors
    localparam int CLK_HZ           = 50_000_000;
    localparam int RESPONSE_MS      = 100;
    localparam int RESPONSE_CYCLES  = (CLK_HZ / 1000) * RESPONSE_MS;

    // ahb transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] vcc;
        logic [15:0] bias;
        logic [15:0] txPwr;
        logic [15:0] rxPwr;
    } tdf_meas_t;

    typedef struct packed {
        logic [15:0] hiAlarm;
        logic [15:0] loAlarm;
        logic [15:0] hiWarn;
        logic [15:0] loWarn;
    } tdf_limit_t;

    typedef struct packed {
        tdf_limit_t temp;
        tdf_limit_t vcc;
        tdf_limit_t bias;
        tdf_limit_t txPwr;
        tdf_limit_t rxPwr;
    } tdf_thr_t;

    // pin levels seen by the bank
    typedef struct packed {
        logic txDisablePin;
        logic laserFault;
        logic receiveSignalLossOutput;
    } tdf_pins_t;

    typedef struct packed {
        logic        wrPend;
        logic [7:0]  wrIdx;
        logic [31:0] rdata;
        logic        softTx;
        logic        txOff;
        logic        stsTxPin;
        logic        stsFault;
        logic        stsLos;
        logic        notReady;
        logic [7:0]  alarmUp;
        logic [1:0]  alarmLo;
        logic [7:0]  warnUp;
        logic [1:0]  warnLo;
    } tdf_state_t;

endpackage : tdf_pkg

// ---- sim/tdf_host_model.sv ----
// host-side ahb-lite master model issuing single word transfers
`timescale 1ns/1ps
`default_nettype none
module tdf_host_model
    import tdf_pkg::*;
(
    // clock
    input  wire logic        core_clk,
    // ahb-lite answer from the slave
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // ahb-lite request
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // one single transfer; no wait count is assumed, only hready ends a wait
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~{22'h0, idx, 2'b00};
        hwdata <= wr ? wd : ~hwdata;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rd = hrdata;
        // released data lines carry a changed pattern, never the old word
        hwdata <= ~wd;
    endtask : xfer
endmodule : tdf_host_model
`default_nettype wire

// ---- sim/transceiver_diag_status_flags_tb_top.sv ----
// self-checking bench for the diagnostic status and flag bank
`timescale 1ns/1ps
`default_nettype none
module transceiver_diag_status_flags_tb_top
    import tdf_pkg::*;
    ;
    logic        core_clk, rst, ce, measUpdate;
    logic        hsel, hwrite, hreadyout, hresp, txDisableOut;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    tdf_pins_t   pins;
    tdf_meas_t   meas;
    tdf_thr_t    thr;
    int          n_errors, checks_done;
    // value levels: above hi alarm, hi warn band, nominal, lo warn band,
    // below lo alarm, exactly hi alarm, exactly lo alarm
    int          lv[7]   = '{1100, 900, 500, 150, 50, 1000, 100};
    logic [1:0]  aexp[7] = '{2'b10, 2'b00, 2'b00, 2'b00, 2'b01, 2'b00, 2'b00};
    logic [1:0]  wexp[7] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b01, 2'b10, 2'b01};

    tdf_diag_flags tdf_diag_flags_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .meas(meas),
        .thr(thr), .measUpdate(measUpdate), .txDisableOut(txDisableOut)
    );
    tdf_host_model tdf_host_model_inst (
        .core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata)
    );

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        tdf_host_model_inst.xfer(1'b0, idx, 32'h0, rd);
        check(rd, exp);
    endtask : rd_chk

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        tdf_host_model_inst.xfer(1'b1, idx, d, rd);
    endtask : wr

    // temperature limits sit 600 lower so that some of them are negative
    function automatic int off(input int q);
        return (q == 0) ? 600 : 0;
    endfunction : off

    function automatic tdf_limit_t lim(input int o);
        return '{16'(1000 - o), 16'(100 - o), 16'(800 - o), 16'(200 - o)};
    endfunction : lim

    function automatic tdf_meas_t meas_of(input int q, input int v);
        tdf_meas_t m;
        m = '{16'(-100), 16'(500), 16'(500), 16'(500), 16'(500)};
        case (q)
            0: m.temp = 16'(v);
            1: m.vcc = 16'(v);
            2: m.bias = 16'(v);
            3: m.txPwr = 16'(v);
            default: m.rxPwr = 16'(v);
        endcase
        return m;
    endfunction : meas_of

    task automatic flag_case(input int q, input int k);
        logic [31:0] au, al, wu, wl;
        int          sh;
        sh = (q < 4) ? 6 - 2 * q : 6;
        au = (q < 4) ? 32'(aexp[k]) << sh : 32'h0;
        wu = (q < 4) ? 32'(wexp[k]) << sh : 32'h0;
        al = (q == 4) ? 32'(aexp[k]) << sh : 32'h0;
        wl = (q == 4) ? 32'(wexp[k]) << sh : 32'h0;
        @(posedge core_clk);
        meas       <= meas_of(q, lv[k] - off(q));
        measUpdate <= 1'b1;
        @(posedge core_clk);
        measUpdate <= 1'b0;
        rd_chk(IDX_ALARM_UP, au);
        rd_chk(IDX_ALARM_LO, al);
        rd_chk(IDX_WARN_UP, wu);
        rd_chk(IDX_WARN_LO, wl);
    endtask : flag_case

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        int bits[3] = '{STS_TXPIN_BIT, STS_FAULT_BIT, STS_LOS_BIT};
        logic [31:0] e;
        rst = 1'b1;
        ce = 1'b1;
        measUpdate = 1'b0;
        pins = '0;
        meas = meas_of(1, 500);
        thr = '{lim(600), lim(0), lim(0), lim(0), lim(0)};
        n_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(IDX_STATUS, 32'h01);
        check({31'h0, hresp}, 32'h0);
        rd_chk(IDX_ALARM_UP, 32'h0);
        rd_chk(8'h72, 32'h0);
        // each pin alone, before any measurement, so not-ready stays set
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            pins <= 3'(4 >> i);
            e = (32'h1 << bits[i]) | 32'h1;
            rd_chk(IDX_STATUS, e);
            check({31'h0, txDisableOut}, (i == 0) ? 32'h1 : 32'h0);
        end
        @(posedge core_clk);
        pins <= '0;
        wr(IDX_STATUS, 32'hffff_ffff);
        rd_chk(IDX_STATUS, 32'h41);
        check({31'h0, txDisableOut}, 32'h1);
        @(posedge core_clk);
        pins.txDisablePin <= 1'b1;
        wr(IDX_STATUS, 32'h0);
        rd_chk(IDX_STATUS, 32'h81);
        check({31'h0, txDisableOut}, 32'h1);
        @(posedge core_clk);
        pins.txDisablePin <= 1'b0;
        repeat (3) @(posedge core_clk);
        check({31'h0, txDisableOut}, 32'h0);
        wr(IDX_ALARM_UP, 32'hffff_ffff);
        rd_chk(IDX_ALARM_UP, 32'h0);
        // a stalled bank holds hready low, then mirrors the pin once it runs again
        @(posedge core_clk);
        ce <= 1'b0;
        pins.laserFault <= 1'b1;
        repeat (3) @(posedge core_clk);
        check({31'h0, hreadyout}, 32'h0);
        ce <= 1'b1;
        rd_chk(IDX_STATUS, 32'h05);
        @(posedge core_clk);
        pins <= '0;
        for (int q = 0; q < 5; q++) begin
            for (int k = 0; k < 7; k++) begin
                flag_case(q, k);
            end
        end
        rd_chk(IDX_STATUS, 32'h00);
        // a second reset must drop the soft inhibit and re-arm not-ready
        wr(IDX_STATUS, 32'h0000_0040);
        rd_chk(IDX_STATUS, 32'h40);
        check({31'h0, txDisableOut}, 32'h1);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(IDX_STATUS, 32'h01);
        check({31'h0, txDisableOut}, 32'h0);
        print_verdict();
    end
endmodule : transceiver_diag_status_flags_tb_top
`default_nettype wire
